/* rtl/ext_irq_consts.vh */
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH

// register byte offsets on the apb bus
`define OFS_ASYNC_SENSE   12'h000
`define OFS_SYNC_SENSE    12'h004
`define OFS_PIN_MASK      12'h008
`define OFS_PIN_FLAGS     12'h00c

// reset values
`define RST_ASYNC_SENSE   8'h00
`define RST_SYNC_SENSE    8'h00
`define RST_PIN_MASK      8'h00
`define RST_PIN_FLAGS     8'h00

// two-bit sense field codes
`define SENSE_LOW         2'b00
`define SENSE_ANY         2'b01
`define SENSE_FALL        2'b10
`define SENSE_RISE        2'b11

// field layout
`define SENSE_W           2
`define NUM_PINS          8
`define NUM_ASYNC         4

// minimum asynchronous pulse width, and its count of pclk cycles
`define T_INT_NS          50
`define CLK_PERIOD_NS     50
`define T_INT_CYC         ((`T_INT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/external_pin_interrupts.v */
`timescale 1ns/1ps
`include "ext_irq_consts.vh"

module external_pin_interrupts (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  input  wire [7:0]  ext_request_pins,
  input  wire        global_irq_enable,
  input  wire [7:0]  vector_ack,
  input  wire        wdt_clk,
  input  wire        startup_done,
  output wire [7:0]  pin_irq_req,
  output wire        irq,
  output wire        wake_req
);

  reg  [7:0]  async_sense_control_q;
  reg  [7:0]  sync_sense_control_q;
  reg  [7:0]  pin_irq_mask_q;
  reg  [7:0]  pin_irq_flags_q;
  reg  [7:0]  pin_irq_flags_d;
  reg  [31:0] prdata_q;
  reg  [31:0] rdata_d;
  reg         slverr_q;
  reg         unmapped_d;
  reg  [7:0]  wdt_meta_q;
  reg  [7:0]  wdt_s1_q;
  reg  [7:0]  wdt_s2_q;
  reg         level_wake_q;
  reg         sup_meta_q;
  reg         sup_sync_q;

  wire [15:0] sense_all;
  wire [7:0]  level_mode;
  wire [7:0]  edge_event;
  wire [7:0]  pin_low;
  wire [3:0]  async_pending;
  wire [3:0]  rise_seen;
  wire [3:0]  fall_seen;
  wire [7:0]  flags_vis;
  wire [7:0]  wr_data;
  wire        setup;
  wire        wr_en;
  wire        wr_async;
  wire        wr_sync;
  wire        wr_mask;
  wire        wr_flags;
  wire [7:0]  level_req;
  wire [3:0]  async_wake;

  assign sense_all = {sync_sense_control_q, async_sense_control_q};
  assign pin_low   = ~ext_request_pins;

  // pins 0 to 3: edges caught on the pin itself, toggles cross into pclk
  genvar i;
  generate
    for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_pin
      wire [1:0] sense = sense_all[i*`SENSE_W +: `SENSE_W];
      assign level_mode[i] = (sense == `SENSE_LOW);
      if (i < `NUM_ASYNC) begin : g_async
        wire r_lvl;
        wire r_rise;
        wire r_fall;
        wire f_lvl;
        wire f_rise;
        wire f_fall;
        reg  rise_tog_q;
        reg  fall_tog_q;
        // a toggle per edge survives a pulse too short for pclk to see
        // async rising capture
        always @(posedge ext_request_pins[i] or negedge presetn) begin
          if (!presetn) begin
            rise_tog_q <= 1'b0;
          end else begin
            rise_tog_q <= ~rise_tog_q;
          end
        end
        always @(negedge ext_request_pins[i] or negedge presetn) begin
          if (!presetn) begin
            fall_tog_q <= 1'b0;
          end else begin
            fall_tog_q <= ~fall_tog_q;
          end
        end
        pin_sync_edge u_rise_sync (
          .clk   (pclk),
          .rst_n (presetn),
          .din   (rise_tog_q),
          .level (r_lvl),
          .rise  (r_rise),
          .fall  (r_fall)
        );
        pin_sync_edge u_fall_sync (
          .clk   (pclk),
          .rst_n (presetn),
          .din   (fall_tog_q),
          .level (f_lvl),
          .rise  (f_rise),
          .fall  (f_fall)
        );
        assign rise_seen[i] = r_rise | r_fall;
        assign fall_seen[i] = f_rise | f_fall;
        // caught but not yet synchronised, so wake works while pclk is stopped
        // clockless wake from a caught edge
        assign async_pending[i] = ((sense == `SENSE_RISE) & (rise_tog_q ^ r_lvl)) |
                                  ((sense == `SENSE_FALL) & (fall_tog_q ^ f_lvl)) |
                                  ((sense == `SENSE_ANY) & ((rise_tog_q ^ r_lvl) | (fall_tog_q ^ f_lvl)));
        assign edge_event[i] = ((sense == `SENSE_RISE) & rise_seen[i]) |
                               ((sense == `SENSE_FALL) & fall_seen[i]) |
                               ((sense == `SENSE_ANY) & (rise_seen[i] | fall_seen[i]));
      end else begin : g_sync
        wire s_rise;
        wire s_fall;
        pin_sync_edge u_pin_sync (
          .clk   (pclk),
          .rst_n (presetn),
          .din   (ext_request_pins[i]),
          .level (),
          .rise  (s_rise),
          .fall  (s_fall)
        );
        assign edge_event[i] = ((sense == `SENSE_RISE) & s_rise) |
                               ((sense == `SENSE_FALL) & s_fall) |
                               ((sense == `SENSE_ANY) & (s_rise | s_fall));
      end
    end
  endgenerate

  // apb slave: zero wait states, read data captured in the setup cycle
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & ~unmapped_d;
  // only the low byte of each word is implemented
  assign wr_data = pwdata[7:0];
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q & psel & penable;

  // per-register write strobes
  assign wr_async = wr_en & (paddr == `OFS_ASYNC_SENSE);
  assign wr_sync  = wr_en & (paddr == `OFS_SYNC_SENSE);
  assign wr_mask  = wr_en & (paddr == `OFS_PIN_MASK);
  assign wr_flags = wr_en & (paddr == `OFS_PIN_FLAGS);

  assign flags_vis = pin_irq_flags_q & ~level_mode;

  // unused or unaligned offsets answer with pslverr
  always @* begin
    rdata_d    = 32'h0000_0000;
    unmapped_d = 1'b0;
    if (paddr == `OFS_ASYNC_SENSE) begin
      rdata_d[7:0] = async_sense_control_q;
    end else if (paddr == `OFS_SYNC_SENSE) begin
      rdata_d[7:0] = sync_sense_control_q;
    end else if (paddr == `OFS_PIN_MASK) begin
      rdata_d[7:0] = pin_irq_mask_q;
    end else if (paddr == `OFS_PIN_FLAGS) begin
      rdata_d[7:0] = flags_vis;
    end else begin
      unmapped_d = 1'b1;
    end
  end

  always @* begin
    pin_irq_flags_d = pin_irq_flags_q;
    if (wr_flags) begin
      pin_irq_flags_d = pin_irq_flags_d & ~wr_data;
    end
    pin_irq_flags_d = pin_irq_flags_d & ~vector_ack;
    pin_irq_flags_d = (pin_irq_flags_d | edge_event) & ~level_mode;
  end

  // apb read capture in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      slverr_q <= unmapped_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_irq_flags_q <= `RST_PIN_FLAGS;
    end else begin
      pin_irq_flags_q <= pin_irq_flags_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_sense_control_q <= `RST_ASYNC_SENSE;
    end else if (wr_async) begin
      async_sense_control_q <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sense_control_q <= `RST_SYNC_SENSE;
    end else if (wr_sync) begin
      sync_sense_control_q <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_irq_mask_q <= `RST_PIN_MASK;
    end else if (wr_mask) begin
      pin_irq_mask_q <= wr_data;
    end
  end

  // pad level used whatever the pin direction
  assign level_req   = level_mode & pin_low & pin_irq_mask_q;
  assign async_wake  = async_pending & pin_irq_mask_q[3:0];

  assign pin_irq_req = ((flags_vis & pin_irq_mask_q) | level_req) & {`NUM_PINS{global_irq_enable}};
  assign irq         = |pin_irq_req;

  // start-up flag brought into the watchdog domain
  always @(posedge wdt_clk or negedge presetn) begin
    if (!presetn) begin
      sup_meta_q <= 1'b0;
      sup_sync_q <= 1'b0;
    end else begin
      sup_meta_q <= startup_done;
      sup_sync_q <= sup_meta_q;
    end
  end

  // watchdog-clock level sampler for wake from power-down
  // configuration is static while asleep, so sampling it per bit is safe
  always @(posedge wdt_clk or negedge presetn) begin
    if (!presetn) begin
      wdt_meta_q <= 8'h00;
      wdt_s1_q   <= 8'h00;
      wdt_s2_q   <= 8'h00;
    end else begin
      wdt_meta_q <= level_req;
      wdt_s1_q   <= wdt_meta_q;
      wdt_s2_q   <= wdt_s1_q;
    end
  end

  // two samples latch wake until start-up
  always @(posedge wdt_clk or negedge presetn) begin
    if (!presetn) begin
      level_wake_q <= 1'b0;
    end else if (|(wdt_s1_q & wdt_s2_q)) begin
      level_wake_q <= 1'b1;
    end else if (sup_sync_q) begin
      level_wake_q <= 1'b0;
    end
  end

  // wake alone, no level request kept
  assign wake_req = level_wake_q | (|async_wake) | (|level_req);

endmodule // external_pin_interrupts

/* rtl/pin_sync_edge.v */
`timescale 1ns/1ps

// two-stage synchroniser followed by a change detector
module pin_sync_edge (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule // pin_sync_edge

/* verif/board_pins.sv */
`timescale 1ns/1ps
module board_pins (
  input  wire        pclk,
  input  wire  [7:0] want,
  output logic [7:0] pins
);
  logic hold_q = 1'b0;
  initial pins = 8'hff;
  always @(posedge pclk) begin
    if (!hold_q && want !== pins) begin
      pins <= want;
      hold_q <= 1'b1;
    end else begin
      hold_q <= 1'b0;
    end
  end
endmodule // board_pins

/* verif/ext_irq_chk.sv */
`timescale 1ns/1ps
`include "ext_irq_consts.vh"
module ext_irq_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [7:0]  ext_request_pins,
  input wire        global_irq_enable,
  input wire [7:0]  pin_irq_req,
  input wire        irq,
  input wire        wake_req
);
  logic [7:0] sa_q, ss_q, mk_q;
  // shadow of the configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_q <= 8'h00;
      ss_q <= 8'h00;
      mk_q <= 8'h00;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `OFS_ASYNC_SENSE: sa_q <= pwdata[7:0];
        `OFS_SYNC_SENSE: ss_q <= pwdata[7:0];
        `OFS_PIN_MASK: mk_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_low0;
    sa_q[1:0] == `SENSE_LOW && mk_q[0] && !ext_request_pins[0];
  endsequence
  sequence s_rise4;
    $rose(ext_request_pins[4]) && ss_q[1:0] == `SENSE_RISE && mk_q[4] && global_irq_enable;
  endsequence
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; psel && penable |-> pslverr == !(paddr == `OFS_ASYNC_SENSE || paddr == `OFS_SYNC_SENSE ||
    paddr == `OFS_PIN_MASK || paddr == `OFS_PIN_FLAGS); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_rd; psel && penable && !pwrite && paddr == `OFS_PIN_MASK |-> prdata == {24'h0, mk_q}; endproperty
  a_rd: assert property (p_rd) else $error("mask readback wrong");
  property p_irq; irq == |pin_irq_req; endproperty
  a_irq: assert property (p_irq) else $error("irq not or of requests");
  property p_gie; !global_irq_enable |-> pin_irq_req == 8'h00; endproperty
  a_gie: assert property (p_gie) else $error("request with gie off");
  property p_mask; (pin_irq_req & ~mk_q) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("masked pin requests");
  property p_level; s_low0 ##0 global_irq_enable |-> pin_irq_req[0]; endproperty
  a_level: assert property (p_level) else $error("low level not requested");
  property p_wake; s_low0 |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("no wake on low level");
  property p_edge4; s_rise4 |-> ##[1:4] pin_irq_req[4]; endproperty
  a_edge4: assert property (p_edge4) else $error("rising edge missed");
endmodule // ext_irq_chk
bind external_pin_interrupts ext_irq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .ext_request_pins, .global_irq_enable, .pin_irq_req, .irq, .wake_req);

/* verif/tb_external_pin_interrupts.sv */
`timescale 1ns/1ps
`include "ext_irq_consts.vh"
module tb_external_pin_interrupts;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        gie = 1'b0, wdt_clk = 1'b0, sup = 1'b1, pready, pslverr, irq, wake, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  want = 8'hff, vack = 8'h00, pins, req;
  integer      mismatches = 0, n_tests = 0, seed = 55, cyc = 0, i, c;
  always #25 pclk = ~pclk;
  always #500 wdt_clk = ~wdt_clk;
  external_pin_interrupts u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .ext_request_pins(pins), .global_irq_enable(gie), .vector_ack(vack),
    .wdt_clk, .startup_done(sup), .pin_irq_req(req), .irq, .wake_req(wake));
  board_pins u_pins (.pclk, .want, .pins);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped slot refused
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset read", 32'h0, rd);
      chk("pslverr", 32'(i == 4), 32'(er));
    end
    for (i = 0; i < 3; i++) begin
      c = $random(seed);
      apb(1'b1, 12'(4 * i), c);
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("readback", c & 32'hff, rd);
    end
    apb(1'b1, `OFS_ASYNC_SENSE, 32'h0);
    gie <= 1'b1;
    for (i = 0; i < 8; i++) begin
      c = (i < 4) ? i : 7 - i;
      apb(1'b1, `OFS_PIN_MASK, 32'h0);
      apb(1'b1, (i < 4) ? `OFS_ASYNC_SENSE : `OFS_SYNC_SENSE, c << (2 * (i % 4)));
      apb(1'b1, `OFS_PIN_FLAGS, 32'hff);
      apb(1'b1, `OFS_PIN_MASK, 32'h1 << i);
      want <= ~(8'h01 << i);
      repeat (6) @(posedge pclk);
      chk("level request", 32'(c != 3), 32'(req[i]));
      if (c == 0) chk("wake", 32'h1, 32'(wake));
      apb(1'b0, `OFS_PIN_FLAGS, 32'h0);
      chk("flag after fall", 32'(c == 1 || c == 2) << i, rd);
      want <= 8'hff;
      repeat (6) @(posedge pclk);
      apb(1'b0, `OFS_PIN_FLAGS, 32'h0);
      chk("flag after rise", 32'(c != 0) << i, rd);
      chk("irq", 32'(c != 0), 32'(irq));
      gie <= 1'b0;
      @(negedge pclk);
      chk("irq gie off", 32'h0, 32'(irq));
      @(posedge pclk);
      gie <= 1'b1;
      if (i % 2) apb(1'b1, `OFS_PIN_FLAGS, 32'h1 << i);
      else begin
        vack <= 8'h01 << i;
        @(posedge pclk);
        vack <= 8'h00;
        @(posedge pclk);
      end
      apb(1'b0, `OFS_PIN_FLAGS, 32'h0);
      chk("flag cleared", 32'h0, rd);
    end
    // level wake latch while start-up is still running
    sup <= 1'b0;
    apb(1'b1, `OFS_ASYNC_SENSE, 32'h0);
    apb(1'b1, `OFS_PIN_MASK, 32'h1);
    want <= 8'hfe;
    repeat (80) @(posedge pclk);
    want <= 8'hff;
    repeat (4) @(posedge pclk);
    chk("level wake held", 32'h1, 32'(wake));
    chk("no level request", 32'h0, 32'(req[0]));
    sup <= 1'b1;
    repeat (100) @(posedge pclk);
    chk("wake released", 32'h0, 32'(wake));
    stop_test;
  end
endmodule // tb_external_pin_interrupts
